// ==== src/mas_pkg.sv ====
package mas_pkg;
	// clock period of CLOCK
	localparam int CLK_NS = 25;

	// pin-level times, as printed or chosen
	localparam int SAMPLE_NS  = 100;  // write strobe low, tracking time
	localparam int GAP_NS     = 50;   // chip select high before next start
	localparam int RDW_MIN_NS = 200;  // pipelined read pulse, least
	localparam int RDW_MAX_NS = 400;  // pipelined read pulse, most
	localparam int EARLY_NS   = 350;  // earliest read after write rises
	localparam int DONE_NS    = 560;  // early-read conversion plus access
	localparam int INTL_NS    = 690;  // conversion-done latest after write
	localparam int REDUCED_NS = 705;  // data valid, reduced interface
	localparam int RO_TMO_NS  = 1000; // read-only wait limit
	localparam int SYNC_CYC   = 2;    // input synchroniser depth

	// cycle counts: least times round up, longest round down
	localparam logic [7:0] SAMPLE_CYC  = 8'((SAMPLE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] GAP_CYC     = 8'((GAP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RDW_CYC     = 8'((RDW_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RDW_MAX_CYC = 8'(RDW_MAX_NS / CLK_NS);
	localparam logic [7:0] EARLY_CYC   = 8'((EARLY_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] ACCESS_CYC  =
		8'((DONE_NS - EARLY_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
	localparam logic [7:0] INTL_CYC    = 8'(INTL_NS / CLK_NS);
	localparam logic [7:0] REDUCED_CYC =
		8'((REDUCED_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
	localparam logic [7:0] RO_TMO_CYC  = 8'(RO_TMO_NS / CLK_NS);

	// pipelined reads discarded after reset
	localparam logic [1:0] PIPE_DISCARD = 2'h2;

	// reset values of the strobes
	localparam logic PIN_IDLE = 1'b1;

	// options chosen by the user side, held per conversion
	typedef struct packed {
		logic wr_rd;    // 0 read-only, 1 write-then-read
		logic pipe;     // read-only: pipelined short pulses
		logic early;    // write-then-read: read without waiting
		logic reduced;  // write-then-read: chip select and read held low
	} mas_cfg_t;

	// strobes driven to the converter
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic mode;
	} mas_pins_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_WAIT,
		ST_RD_PULSE,
		ST_WR_LOW,
		ST_CONV_WAIT,
		ST_INT_WAIT,
		ST_RD_ACC,
		ST_GAP
	} mas_state_t;
endpackage

// ==== src/mas_host.sv ====
`timescale 1ns/1ps
// Functional notes
// - static mode pin: low read-only, high write-then-read.
// - read-only: read strobe held low all conversion, result after about 655 ns.
// - host waits 50 ns after chip select rises before next read.
// - pipelined read pulses stay between 200 ns and 400 ns wide.
// - host may read 350 ns after write rises without waiting.
// - chip select and read tied low: write alone converts, valid after 705 ns.
module mas_host
	import mas_pkg::*;
(
	input  wire logic              CLOCK,         // 40 MHz clock
	input  wire logic              RST_N,         // async reset, active low
	input  wire logic              START,         // one-cycle conversion request
	input  wire mas_pkg::mas_cfg_t CFG,           // options, sampled with START
	input  wire logic              ADC_INT_N,     // conversion-done from converter
	input  wire logic              ADC_RDY,       // busy/acknowledge from converter
	input  wire logic [7:0]        ADC_DATA,      // result_bus as seen by the host
	output mas_pkg::mas_pins_t     ADC_PINS,      // strobes and mode to converter
	output logic [7:0]             RESULT,        // last captured result
	output logic                   RESULT_VALID,  // one-cycle pulse, RESULT fresh
	output logic                   TIMEOUT,       // one-cycle pulse, done never seen
	output logic                   BUSY,          // host sequence in progress
	output logic                   ADC_BUSY       // converter reports busy
);
	import mas_pkg::*;

	// two-flop synchronisers for the converter pins
	logic       int_n_meta, int_n_s;
	logic       rdy_meta, rdy_s;
	logic [7:0] data_meta, data_s;

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			int_n_meta <= 1'b1;
			int_n_s    <= 1'b1;
			rdy_meta   <= 1'b1;
			rdy_s      <= 1'b1;
			data_meta  <= 8'h00;
			data_s     <= 8'h00;
		end else begin
			int_n_meta <= ADC_INT_N;
			int_n_s    <= int_n_meta;
			rdy_meta   <= ADC_RDY;
			rdy_s      <= rdy_meta;
			data_meta  <= ADC_DATA;
			data_s     <= data_meta;
		end
	end

	mas_state_t state, next_state;
	mas_cfg_t   cfg, next_cfg;
	mas_pins_t  pins, next_pins;
	logic [7:0] cnt, next_cnt;
	logic [7:0] result, next_result;
	logic [1:0] reads, next_reads;
	logic       valid, next_valid;
	logic       tmo, next_tmo;
	logic       busy, next_busy;
	logic       adc_busy, next_adc_busy;

	// sequencer next-state logic
	always_comb begin
		next_state    = state;
		next_cfg      = cfg;
		next_pins     = pins;
		next_cnt      = (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
		next_result   = result;
		next_reads    = reads;
		next_valid    = 1'b0;
		next_tmo      = 1'b0;
		next_busy     = busy;
		next_adc_busy = ~rdy_s;
		unique case (state)
			ST_IDLE: begin
				next_pins.mode = cfg.wr_rd;
				if (START) begin
					next_cfg       = CFG;
					next_busy      = 1'b1;
					next_pins.mode = CFG.wr_rd;
					next_pins.cs_n = 1'b0;
					if (!CFG.wr_rd) begin
						next_pins.rd_n = 1'b0;
						next_cnt       = CFG.pipe ? RDW_CYC : RO_TMO_CYC;
						next_state     = CFG.pipe ? ST_RD_PULSE : ST_RD_WAIT;
					end else begin
						next_pins.wr_n = 1'b0;
						next_pins.rd_n = ~CFG.reduced;
						next_cnt       = SAMPLE_CYC;
						next_state     = ST_WR_LOW;
					end
				end
			end
			ST_RD_WAIT: begin
				// read held low until conversion-done; a low left over from the
				// last conversion sits in the synchroniser for two more cycles
				if ((!int_n_s && cnt <= RO_TMO_CYC - 8'(SYNC_CYC))
						|| cnt == 8'h00) begin
					next_result    = data_s;
					next_valid     = ~int_n_s;
					next_tmo       = int_n_s;
					next_pins.rd_n = 1'b1;
					next_pins.cs_n = 1'b1;
					next_cnt       = GAP_CYC;
					next_state     = ST_GAP;
				end
			end
			ST_RD_PULSE: begin
				// fixed-width pulse, bus shows previous result
				if (cnt == 8'h01) begin
					next_result    = data_s;
					next_valid     = (reads == PIPE_DISCARD);
					if (reads != PIPE_DISCARD) begin
						next_reads = reads + 2'h1;
					end
					next_pins.rd_n = 1'b1;
					next_pins.cs_n = 1'b1;
					next_cnt       = GAP_CYC;
					next_state     = ST_GAP;
				end
			end
			ST_WR_LOW: begin
				// tracking; rising write starts the conversion
				if (cnt == 8'h01) begin
					next_pins.wr_n = 1'b1;
					if (cfg.reduced) begin
						next_cnt   = REDUCED_CYC;
						next_state = ST_CONV_WAIT;
					end else if (cfg.early) begin
						next_cnt   = EARLY_CYC;
						next_state = ST_CONV_WAIT;
					end else begin
						next_cnt   = INTL_CYC;
						next_state = ST_INT_WAIT;
					end
				end
			end
			ST_CONV_WAIT: begin
				if (cnt == 8'h01) begin
					if (cfg.reduced) begin
						next_result    = data_s;
						next_valid     = 1'b1;
						next_pins.rd_n = 1'b1;
						next_pins.cs_n = 1'b1;
						next_cnt       = GAP_CYC;
						next_state     = ST_GAP;
					end else begin
						next_pins.rd_n = 1'b0;
						next_cnt       = ACCESS_CYC;
						next_state     = ST_RD_ACC;
					end
				end
			end
			ST_INT_WAIT: begin
				// done expected within its longest delay; stale low ignored
				if ((!int_n_s && cnt <= INTL_CYC - 8'(SYNC_CYC))
						|| cnt == 8'h00) begin
					next_tmo       = int_n_s;
					next_pins.rd_n = 1'b0;
					next_cnt       = 8'(SYNC_CYC + 1);
					next_state     = ST_RD_ACC;
				end
			end
			ST_RD_ACC: begin
				if (cnt == 8'h01) begin
					next_result    = data_s;
					next_valid     = 1'b1;
					next_pins.rd_n = 1'b1;
					next_pins.cs_n = 1'b1;
					next_cnt       = GAP_CYC;
					next_state     = ST_GAP;
				end
			end
			ST_GAP: begin
				// chip select high before the next start
				if (cnt == 8'h01 || cnt == 8'h00) begin
					next_busy  = 1'b0;
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state    <= ST_IDLE;
			cfg      <= '0;
			pins     <= '{cs_n: PIN_IDLE, rd_n: PIN_IDLE, wr_n: PIN_IDLE, mode: 1'b0};
			cnt      <= 8'h00;
			result   <= 8'h00;
			reads    <= 2'h0;
			valid    <= 1'b0;
			tmo      <= 1'b0;
			busy     <= 1'b0;
			adc_busy <= 1'b0;
		end else begin
			state    <= next_state;
			cfg      <= next_cfg;
			pins     <= next_pins;
			cnt      <= next_cnt;
			result   <= next_result;
			reads    <= next_reads;
			valid    <= next_valid;
			tmo      <= next_tmo;
			busy     <= next_busy;
			adc_busy <= next_adc_busy;
		end
	end

	assign ADC_PINS     = pins;
	assign RESULT       = result;
	assign RESULT_VALID = valid;
	assign TIMEOUT      = tmo;
	assign BUSY         = busy;
	assign ADC_BUSY     = adc_busy;
endmodule // mas_host

// ==== verif/mas_host_assertions.sv ====
`timescale 1ns/1ps
module mas_host_checker
	import mas_pkg::*;
(
	input wire logic               CLOCK,        // clock
	input wire logic               RST_N,        // reset
	input wire logic               START,        // request
	input wire mas_pkg::mas_cfg_t  CFG,          // options
	input wire logic               ADC_INT_N,    // done
	input wire logic               ADC_RDY,      // ack
	input wire logic [7:0]         ADC_DATA,     // bus
	input wire mas_pkg::mas_pins_t ADC_PINS,     // strobes
	input wire logic [7:0]         RESULT,       // result
	input wire logic               RESULT_VALID, // fresh
	input wire logic               TIMEOUT,      // no done
	input wire logic               BUSY,         // busy
	input wire logic               ADC_BUSY      // adc busy
);
	logic       pipe_q, wr_q;
	logic [1:0] rd_cnt;
	logic [7:0] rd_low;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	// options of the running sequence, reads so far, read low time
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			{pipe_q, wr_q, rd_cnt, rd_low} <= 12'h000;
		end else begin
			if (START && !BUSY) {pipe_q, wr_q} <= {CFG.pipe, CFG.wr_rd};
			if ($rose(ADC_PINS.rd_n) && rd_cnt != 2'h3) rd_cnt <= rd_cnt + 2'h1;
			rd_low <= ADC_PINS.rd_n ? 8'h00 : rd_low + 8'h01;
		end
	end
	a_gap_before_start: assert property ($fell(ADC_PINS.cs_n) |-> $past(ADC_PINS.cs_n, 2))
		else $error("chip select fell without a gap");
	a_mode_held: assert property (!ADC_PINS.cs_n |-> ADC_PINS.mode == wr_q)
		else $error("mode differs from the chosen option");
	a_read_min: assert property ($fell(ADC_PINS.rd_n) && !ADC_PINS.mode |-> !ADC_PINS.rd_n [*8])
		else $error("read pulse too short");
	a_pipe_max: assert property (!ADC_PINS.rd_n && pipe_q |-> rd_low < RDW_MAX_CYC)
		else $error("pipelined read pulse too long");
	a_write_track: assert property ($fell(ADC_PINS.wr_n) |-> !ADC_PINS.wr_n [*4] ##1 ADC_PINS.wr_n)
		else $error("write low time wrong");
	a_write_select: assert property ($rose(ADC_PINS.wr_n) |-> !ADC_PINS.cs_n && ADC_PINS.mode)
		else $error("write rose without select or mode");
	a_early_gap: assert property ($rose(ADC_PINS.wr_n) && ADC_PINS.rd_n |->
		ADC_PINS.rd_n [*8] ##1 ADC_PINS.rd_n [*6]) else $error("read too soon after write");
	a_discard_reads: assert property ($rose(ADC_PINS.rd_n) && pipe_q |->
		RESULT_VALID == (rd_cnt >= 2'h2)) else $error("pipelined read validity wrong");
	a_busy_follow: assert property (ADC_BUSY == !$past(ADC_RDY, 3))
		else $error("converter busy report lags wrongly");
	a_busy_start: assert property (START && !BUSY |=> BUSY && !ADC_PINS.cs_n)
		else $error("accepted request did not select the converter");
endmodule // mas_host_checker

bind mas_host mas_host_checker chk (
	.CLOCK(CLOCK), .RST_N(RST_N), .START(START), .CFG(CFG), .ADC_INT_N(ADC_INT_N),
	.ADC_RDY(ADC_RDY), .ADC_DATA(ADC_DATA), .ADC_PINS(ADC_PINS), .RESULT(RESULT),
	.RESULT_VALID(RESULT_VALID), .TIMEOUT(TIMEOUT), .BUSY(BUSY), .ADC_BUSY(ADC_BUSY)
);

// ==== verif/mas_conv_model.sv ====
`timescale 1ns/1ps
module mas_conv_model
	import mas_pkg::*;
#(
	parameter int CONV_NS = 500  // conversion time
)(
	input  wire mas_pkg::mas_pins_t PINS,  // strobes from host
	input  wire logic               STALL, // withhold done
	output logic                    INT_N, // conversion done
	output logic                    RDY,   // busy/ack
	output logic [7:0]              DATA   // result_bus
);
	logic [7:0] code = 8'h00;
	logic [7:0] latch = 8'hC3;  // junk until a first result
	logic       running = 1'b0;
	localparam int SKEW_NS = 3;  // keeps pin changes off the clock edge
	initial {INT_N, RDY} = 2'h3;
	// one conversion; result and done after the conversion time
	task automatic convert();
		{INT_N, RDY, running} = 3'h5;
		code = code + 8'h25;
		#(CONV_NS + SKEW_NS);
		{RDY, running} = 2'h2;
		if (!STALL) {INT_N, latch} = {1'b0, code};
	endtask
	// busy once selected
	always @(negedge PINS.cs_n) RDY = 1'b0;
	// read-only: read fall starts, bus keeps the previous result
	always @(negedge PINS.rd_n) begin
		if (!PINS.cs_n && !PINS.mode) convert();
		else if (!PINS.cs_n && running && INT_N) {INT_N, latch} = {1'b0, code};
	end
	// write rise holds the sample and starts
	always @(posedge PINS.wr_n) if (!PINS.cs_n && PINS.mode) convert();
	// bus only while selected and read, else a changed value
	assign DATA = (!PINS.cs_n && !PINS.rd_n) ? latch : ~latch;
endmodule // mas_conv_model

// ==== verif/mas_host_test.sv ====
`timescale 1ns/1ps
module mas_host_test;
	import mas_pkg::*;
	localparam logic [7:0] STEP = 8'h25;  // model code step per conversion
	logic       clk, rst_n, start, stall, valid, tmo;
	mas_cfg_t   cfg;
	mas_pins_t  pins;
	wire        int_n, rdy;
	wire  [7:0] data;
	logic [7:0] result;
	int         error_cnt = 0;
	int         checks = 0;
	mas_host uut (
		.CLOCK(clk), .RST_N(rst_n), .START(start), .CFG(cfg), .ADC_INT_N(int_n),
		.ADC_RDY(rdy), .ADC_DATA(data), .ADC_PINS(pins), .RESULT(result),
		.RESULT_VALID(valid), .TIMEOUT(tmo), .BUSY(), .ADC_BUSY()
	);
	mas_conv_model conv (.PINS(pins), .STALL(stall), .INT_N(int_n), .RDY(rdy), .DATA(data));
	// verdict
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// one sequence; kind 0 no pulse, 1 result, 2 timeout
	task automatic run(input mas_cfg_t c, input int k, input logic [7:0] e);
		int   n = 0;
		logic ok;
		{start, cfg} = {1'b1, c};
		@(posedge clk);
		#2 start = 1'b0;
		while (valid !== 1'b1 && tmo !== 1'b1 && n < 80) begin
			@(posedge clk);
			#2 n++;
		end
		checks++;
		case (k)
			0: ok = n == 80;
			1: ok = valid === 1'b1 && result === e;
			default: ok = tmo === 1'b1 && valid !== 1'b1;
		endcase
		if (!ok) begin
			error_cnt++;
			$display("unexpected at %0t: kind %0d result %h", $time, k, result);
			if (n == 80) tally_and_finish();
		end
		repeat (30) @(posedge clk);
		#2;
	endtask
	// pipelined: two discarded reads (junk, then the first result), then the previous result
	task automatic t_pipe();
		run(4'h4, 0, 8'h00);
		run(4'h4, 0, 8'h00);
		run(4'h4, 1, 8'(2 * STEP));
	endtask
	// read-only, wait for done
	task automatic t_read_wait();
		run(4'h0, 1, 8'(4 * STEP));
	endtask
	// write then read, wait for done
	task automatic t_write_wait();
		run(4'h8, 1, 8'(5 * STEP));
	endtask
	// write then early read
	task automatic t_early();
		run(4'hA, 1, 8'(6 * STEP));
	endtask
	// select and read held low, write alone
	task automatic t_reduced();
		run(4'h9, 1, 8'(7 * STEP));
	endtask
	// done never comes
	task automatic t_timeout();
		stall = 1'b1;
		run(4'h0, 2, 8'h00);
		stall = 1'b0;
	endtask
	// clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// reset, then scenarios
	initial begin
		{rst_n, start, cfg, stall} = 7'h00;
		repeat (4) @(posedge clk);
		#2 rst_n = 1'b1;
		t_pipe();
		t_read_wait();
		t_write_wait();
		t_early();
		t_reduced();
		t_timeout();
		tally_and_finish();
	end
endmodule // mas_host_test
